// ### fifo_threshold_cfg.svh
/*
 * Constants for the FIFO threshold configuration block: register offsets,
 * field positions, reset values and tuning words.
 * Assumes inclusion by bare name from the design file.
 */
// Functional notes
// - Retention clear: wake loads tuning word one 0x31, word two 0x88.
// - Retention set: wake loads tuning word one 0x35, word two 0x81.
// - Tuning loads stay internal; host reads of tuning registers give reset values.
// - Threshold reached when FIFO byte count is at or above threshold.
// - Code N, reset 7: receive 4(N+1) bytes, transmit 61-4N bytes.
`ifndef FIFO_THRESHOLD_CFG_SVH
`define FIFO_THRESHOLD_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_LEVEL_THRESHOLD 6'h03
`define OFS_TUNING_ONE      6'h2D
`define OFS_TUNING_TWO      6'h2C
`define OFS_IRQ_STATUS      6'h10
`define OFS_IRQ_CLEAR       6'h11
`define OFS_IRQ_ENABLE      6'h12

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define BIT_RESERVED        7
`define BIT_RETENTION       6
`define THR_RESET           8'h07
`define TUNING_ONE_RESET    8'h31
`define TUNING_TWO_RESET    8'h88
`define TUNE1_RET_CLEAR     8'h31
`define TUNE2_RET_CLEAR     8'h88
`define TUNE1_RET_SET       8'h35
`define TUNE2_RET_SET       8'h81
`define TX_THR_BASE         7'h3D
`define RX_THR_BASE         7'h04
`define IRQ_BITS            2

`endif

// ### fifo_threshold_config.sv
/*
 * Threshold register, wake-up tuning load and threshold comparators for
 * the 64-byte transmit and receive FIFOs, with a small interrupt block.
 * Assumes a synchronous register port and FIFO byte counts from the FIFO logic.
 */
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "fifo_threshold_cfg.svh"
`default_nettype none

module fifo_threshold_config (
	input  wire logic                         clk,
	input  wire logic                         resetn,
	input  wire fifo_threshold_pkg::reg_req_t req,
	output logic [7:0]                        rdata,
	input  wire logic [6:0]                   rx_count,
	input  wire logic [6:0]                   tx_count,
	input  wire logic                         sleep,
	output logic                              rx_threshold,
	output logic                              tx_threshold,
	output logic [7:0]                        analog_tuning_word_one,
	output logic [7:0]                        analog_tuning_word_two,
	output logic                              irq
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_meta_r;
	logic rst_n_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// ----------------------------------------
	// Thresholds
	// ----------------------------------------
	fifo_threshold_pkg::state_t s_r;
	fifo_threshold_pkg::state_t s_nxt;
	logic [3:0]                 fill_threshold_code;
	logic                       converter_setting_retention;
	logic [6:0]                 rx_limit;
	logic [6:0]                 tx_limit;
	logic                       rx_cmp;
	logic                       tx_cmp;
	logic                       wake;
	logic                       wr_threshold;
	logic                       wr_clear;
	logic                       wr_enable;
	logic [1:0]                 cmp_rise;

	assign fill_threshold_code         = s_r.thr[3:0];
	assign converter_setting_retention = s_r.thr[`BIT_RETENTION];

	// ----------------------------------------
	// Threshold limits
	// ----------------------------------------
	// Receive limit climbs from 4 in steps of four bytes
	fill_limit #(
		.BASE (`RX_THR_BASE),
		.DOWN (1'b0)
	) rx_limit_gen (
		.code  (fill_threshold_code),
		.limit (rx_limit)
	);

	// Transmit limit falls from 61 in steps of four bytes
	fill_limit #(
		.BASE (`TX_THR_BASE),
		.DOWN (1'b1)
	) tx_limit_gen (
		.code  (fill_threshold_code),
		.limit (tx_limit)
	);

	// ----------------------------------------
	// Comparators
	// ----------------------------------------
	// Combinational, so a count or code change shows at once
	fill_compare #(
		.WIDTH (7)
	) rx_compare (
		.count   (rx_count),
		.limit   (rx_limit),
		.reached (rx_cmp)
	);

	fill_compare #(
		.WIDTH (7)
	) tx_compare (
		.count   (tx_count),
		.limit   (tx_limit),
		.reached (tx_cmp)
	);

	// ----------------------------------------
	// Wake detection
	// ----------------------------------------
	// Sleep level falling against its registered copy
	assign wake = s_r.asleep && !sleep;

	// ----------------------------------------
	// Register port decode
	// ----------------------------------------
	assign wr_threshold = req.wr && (req.addr == `OFS_LEVEL_THRESHOLD);
	assign wr_clear     = req.wr && (req.addr == `OFS_IRQ_CLEAR);
	assign wr_enable    = req.wr && (req.addr == `OFS_IRQ_ENABLE);

	// Threshold crossings from below raise status events
	assign cmp_rise = {tx_cmp & ~s_r.tx_hit, rx_cmp & ~s_r.rx_hit};

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_nxt        = s_r;
		s_nxt.rdata  = 8'h00;
		s_nxt.asleep = sleep;
		s_nxt.rx_hit = rx_cmp;
		s_nxt.tx_hit = tx_cmp;

		// Wake-up load; these values never reach the read path
		if (wake) begin
			if (converter_setting_retention) begin
				s_nxt.tune1 = `TUNE1_RET_SET;
				s_nxt.tune2 = `TUNE2_RET_SET;
			end else begin
				s_nxt.tune1 = `TUNE1_RET_CLEAR;
				s_nxt.tune2 = `TUNE2_RET_CLEAR;
			end
		end

		// Configuration writes; bit 7 is kept as written
		if (wr_threshold) begin
			s_nxt.thr = req.wdata;
		end
		if (wr_enable) begin
			s_nxt.irq_en = req.wdata[1:0];
		end

		// Clear first, then events, so a same-cycle event wins
		if (wr_clear) begin
			s_nxt.irq_stat = s_r.irq_stat & ~req.wdata[1:0];
		end
		s_nxt.irq_stat = s_nxt.irq_stat | cmp_rise;

		// Read data stands only in the cycle after the strobe
		if (req.rd) begin
			unique case (req.addr)
				`OFS_LEVEL_THRESHOLD: s_nxt.rdata = s_r.thr;
				`OFS_TUNING_ONE:      s_nxt.rdata = `TUNING_ONE_RESET;
				`OFS_TUNING_TWO:      s_nxt.rdata = `TUNING_TWO_RESET;
				`OFS_IRQ_STATUS:      s_nxt.rdata = {6'h00, s_r.irq_stat};
				`OFS_IRQ_ENABLE:      s_nxt.rdata = {6'h00, s_r.irq_en};
				default:              s_nxt.rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			s_r.thr      <= `THR_RESET;
			s_r.tune1    <= `TUNING_ONE_RESET;
			s_r.tune2    <= `TUNING_TWO_RESET;
			s_r.irq_stat <= 2'b00;
			s_r.irq_en   <= 2'b00;
			s_r.rdata    <= 8'h00;
			s_r.rx_hit   <= 1'b0;
			s_r.tx_hit   <= 1'b0;
			s_r.asleep   <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata                  = s_r.rdata;
	assign rx_threshold           = rx_cmp;
	assign tx_threshold           = tx_cmp;
	assign analog_tuning_word_one = s_r.tune1;
	assign analog_tuning_word_two = s_r.tune2;
	assign irq                    = |(s_r.irq_stat & s_r.irq_en);

endmodule : fifo_threshold_config

// ----------------------------------------
// Fill limit from threshold code
// ----------------------------------------
module fill_limit #(
	parameter logic [6:0] BASE = 7'h00,
	parameter logic       DOWN = 1'b0
) (
	input  wire logic [3:0] code,
	output logic [6:0]      limit
);

	logic [6:0] step;

	// Four bytes per code step
	assign step  = {1'b0, code, 2'b00};
	assign limit = DOWN ? (BASE - step) : (BASE + step);

endmodule : fill_limit

// ----------------------------------------
// Fill-level comparator
// ----------------------------------------
module fill_compare #(
	parameter int WIDTH = 7
) (
	input  wire logic [WIDTH-1:0] count,
	input  wire logic [WIDTH-1:0] limit,
	output logic                  reached
);

	// At or above the limit counts as reached
	assign reached = count >= limit;

endmodule : fill_compare

`default_nettype wire

// ### fifo_threshold_config_assertions.sv
/* Port checker for the threshold block. Assumes binding onto fifo_threshold_config. */
`timescale 1ns/1ps
`default_nettype none
module fifo_threshold_config_assertions (
	input wire logic                         clk,
	input wire logic                         resetn,
	input wire fifo_threshold_pkg::reg_req_t req,
	input wire logic [7:0]                   rdata,
	input wire logic [6:0]                   rx_count,
	input wire logic [6:0]                   tx_count,
	input wire logic                         sleep,
	input wire logic                         rx_threshold,
	input wire logic                         tx_threshold,
	input wire logic [7:0]                   analog_tuning_word_one,
	input wire logic [7:0]                   analog_tuning_word_two
);
	logic [7:0] thr_r;
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			thr_r <= 8'h07;
		else if (req.wr && req.addr == 6'h03)
			thr_r <= req.wdata;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence wake_s;
		$fell(sleep);
	endsequence
	AST_RX_THR: assert property (rx_threshold == (rx_count >= 4 * ({3'b0, thr_r[3:0]} + 1)))
		else $error("rx threshold wrong");
	AST_TX_THR: assert property (tx_threshold == (tx_count >= 61 - 4 * thr_r[3:0]))
		else $error("tx threshold wrong");
	AST_WAKE_CLR: assert property (wake_s ##0 !thr_r[6] |=> analog_tuning_word_one == 8'h31
		&& analog_tuning_word_two == 8'h88) else $error("wake load wrong");
	AST_WAKE_SET: assert property (wake_s ##0 thr_r[6] |=> analog_tuning_word_one == 8'h35
		&& analog_tuning_word_two == 8'h81) else $error("retained load wrong");
	AST_RD_ONE: assert property (req.rd && req.addr == 6'h2D |=> rdata == 8'h31)
		else $error("word one read wrong");
	AST_RD_TWO: assert property (req.rd && req.addr == 6'h2C |=> rdata == 8'h88)
		else $error("word two read wrong");
	AST_RD_THR: assert property (req.rd && req.addr == 6'h03 |=> rdata == $past(thr_r))
		else $error("threshold read wrong");
	AST_RD_IDLE: assert property (!req.rd |=> rdata == 8'h00)
		else $error("read data not idle");
endmodule : fifo_threshold_config_assertions
bind fifo_threshold_config fifo_threshold_config_assertions chk (.clk(clk), .resetn(resetn), .req(req),
	.rdata(rdata), .rx_count(rx_count), .tx_count(tx_count), .sleep(sleep), .rx_threshold(rx_threshold),
	.tx_threshold(tx_threshold), .analog_tuning_word_one(analog_tuning_word_one),
	.analog_tuning_word_two(analog_tuning_word_two));
`default_nettype wire

// ### fifo_threshold_pkg.sv
/*
 * Types for the FIFO threshold configuration block.
 * Assumes nothing of its surroundings.
 */
package fifo_threshold_pkg;

	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic [7:0] thr;
		logic [7:0] tune1;
		logic [7:0] tune2;
		logic [1:0] irq_stat;
		logic [1:0] irq_en;
		logic [7:0] rdata;
		logic       rx_hit;
		logic       tx_hit;
		logic       asleep;
	} state_t;

endpackage : fifo_threshold_pkg

// ### host_model.sv
/* Host model: register port master and sleep control. Assumes the testbench calls its tasks. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic                         clk,
	output var  fifo_threshold_pkg::reg_req_t req,
	output var  logic                         sleep,
	input  wire logic [7:0]                   rdata
);
	initial begin
		req = '0;
		sleep = 1'b0;
	end
	task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		req <= '{a, d & (a == 6'h03 ? 8'h7F : 8'hFF), w, !w};
		@(posedge clk);
		req <= '0;
		#1 q = rdata;
	endtask : acc
	task automatic nap(input logic ret);
		logic [7:0] q;
		acc(1'b1, 6'h03, {1'b0, ret, 6'h07}, q);
		@(posedge clk);
		sleep <= 1'b1;
		repeat (4) @(posedge clk);
		sleep <= 1'b0;
		@(posedge clk);
		#1;
	endtask : nap
endmodule : host_model
`default_nettype wire

// ### testbench.sv
/* Self-checking bench for the threshold block. Assumes the host model and checker files. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                         clk = 1'b0;
	logic                         resetn = 1'b0;
	logic [6:0]                   rx_count = '0;
	logic [6:0]                   tx_count = '0;
	fifo_threshold_pkg::reg_req_t req;
	logic                         sleep, rx_threshold, tx_threshold, irq;
	logic [7:0]                   rdata, t1, t2, q;
	integer                       failures = 0, num_checks = 0, seed = 32, n, k, c;
	always #2.5 clk = ~clk;
	host_model host (.clk(clk), .req(req), .sleep(sleep), .rdata(rdata));
	fifo_threshold_config DUT (.clk(clk), .resetn(resetn), .req(req), .rdata(rdata), .rx_count(rx_count),
		.tx_count(tx_count), .sleep(sleep), .rx_threshold(rx_threshold), .tx_threshold(tx_threshold),
		.analog_tuning_word_one(t1), .analog_tuning_word_two(t2), .irq(irq));
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic cnt(input integer r, input integer t);
		@(posedge clk);
		rx_count <= r[6:0];
		tx_count <= t[6:0];
		@(negedge clk);
		chk("rx_thr", 8'(r >= 4 * (n + 1)), {7'h0, rx_threshold});
		chk("tx_thr", 8'(t >= 61 - 4 * n), {7'h0, tx_threshold});
	endtask : cnt
	task automatic finish_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		n = 7;
		host.acc(1'b0, 6'h03, 8'h00, q);
		chk("thr", 8'h07, q);
		for (n = 0; n < 16; n++) begin
			host.acc(1'b1, 6'h03, 8'(n), q);
			host.acc(1'b0, 6'h03, 8'h00, q);
			chk("thr", 8'(n), q);
			cnt(4 * n + 3, 60 - 4 * n);
			cnt(4 * n + 4, 61 - 4 * n);
			c = $random(seed);
			cnt(c[6:0] % 65, c[14:8] % 65);
		end
		chk("irq_off", 8'h00, {7'h0, irq});
		for (k = 1; k >= 0; k--) begin
			host.nap(k[0]);
			n = 7;
			chk("tune1", k ? 8'h35 : 8'h31, t1);
			chk("tune2", k ? 8'h81 : 8'h88, t2);
			host.acc(1'b0, 6'h2D, 8'h00, q);
			chk("tune1_rd", 8'h31, q);
			host.acc(1'b0, 6'h2C, 8'h00, q);
			chk("tune2_rd", 8'h88, q);
		end
		host.acc(1'b0, 6'h20, 8'h00, q);
		chk("unmapped", 8'h00, q);
		cnt(0, 0);
		host.acc(1'b1, 6'h11, 8'h03, q);
		host.acc(1'b1, 6'h12, 8'h01, q);
		cnt(64, 64);
		repeat (2) @(posedge clk);
		#1 chk("irq_on", 8'h01, {7'h0, irq});
		host.acc(1'b0, 6'h10, 8'h00, q);
		chk("status", 8'h03, q);
		host.acc(1'b1, 6'h11, 8'h01, q);
		@(posedge clk);
		#1 chk("irq_clr", 8'h00, {7'h0, irq});
		finish_test();
	end
endmodule : testbench
`default_nettype wire
